// ### verilog/ibl_core.sv
// Indirect move and literal load execution with pointer redirection of data accesses.
`timescale 1ns/100ps
// Function
// RULE1 - The indirect move takes a 2-bit mode: 00 preincrement, 01 predecrement, 10 postincrement, 11 postdecrement, pre modes adjusting before the access and post modes after.
// RULE2 - The indirect move transfers one byte between the working register and the indirect access location of the chosen pointer.
// RULE3 - Any access naming an indirect access location is redirected to the data address held in the matching pointer.
// RULE4 - The indirect access locations have no storage and act only as address aliases.
// RULE5 - Each pointer spans 0000h to FFFFh and wraps modulo 16 bits on increment and decrement.
// RULE6 - The bank literal load writes its 6-bit literal into the bank select register.
// RULE7 - The page latch literal load writes its 7-bit literal into the program counter latch high register.
// RULE8 - The working literal load places its 8-bit literal, 0 to 255, into the working register.
// RULE9 - The three literal loads leave every status flag unchanged.
// RULE10 - A literal wider than its destination keeps only the low bits that fit.
module ibl_core #(
   parameter int PTR_W  = ibl_pkg::PTR_W,
   parameter int DATA_W = ibl_pkg::DATA_W
) (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   input  wire logic                  instr_valid,
   input  wire ibl_pkg::ibl_op_t      instr_op,
   input  wire logic                  instr_ptr_sel,
   input  wire logic [1:0]            instr_mode,
   input  wire logic                  instr_to_mem,
   input  wire logic [7:0]            instr_literal,
   input  wire logic                  acc_valid,
   input  wire logic [15:0]           acc_addr,
   input  wire logic                  acc_we,
   input  wire logic [DATA_W-1:0]     acc_wdata,
   input  wire logic [DATA_W-1:0]     mem_rdata,
   output      logic [15:0]           mem_addr_r,
   output      logic                  mem_rd_r,
   output      logic                  mem_wr_r,
   output      logic [DATA_W-1:0]     mem_wdata_r,
   output      logic                  busy_r,
   output      logic [DATA_W-1:0]     w_reg_r,
   output      logic [5:0]            bank_sel_r,
   output      logic [6:0]            program_counter_latch_high_r,
   output      logic [PTR_W-1:0]      ptr0_r,
   output      logic [PTR_W-1:0]      ptr1_r
);
   // Returns whether an address is one of the alias locations.
   function automatic logic is_alias(input logic [15:0] a);
      return (a == ibl_pkg::ALIAS0_ADDR) || (a == ibl_pkg::ALIAS1_ADDR);
   endfunction : is_alias

   // Returns which pointer an alias address stands for.
   function automatic logic alias_sel(input logic [15:0] a);
      return (a == ibl_pkg::ALIAS1_ADDR);
   endfunction : alias_sel

   logic                          rst_meta_r;
   logic                          rst_n_r;
   ibl_pkg::ibl_state_t           state_r;
   ibl_pkg::ibl_state_t           state_nxt;
   logic [2*PTR_W-1:0]            ptr_flat;
   logic [PTR_W-1:0]              ptr_cur;
   logic [PTR_W-1:0]              ptr_adj;
   logic                          mv_go;
   logic                          acc_go;
   logic                          lit_go;
   logic [15:0]                   acc_target;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // New instructions are taken only while idle; a busy core leaves them to the decoder.
   assign mv_go  = ce && instr_valid && (state_r == ibl_pkg::IBL_ST_IDLE)
                   && (instr_op == ibl_pkg::IBL_OP_INDIRECT_MOVE);
   assign lit_go = ce && instr_valid && (state_r == ibl_pkg::IBL_ST_IDLE)
                   && (instr_op != ibl_pkg::IBL_OP_INDIRECT_MOVE);
   // Plain data accesses yield to an instruction in the same cycle.
   assign acc_go = ce && acc_valid && !instr_valid && (state_r == ibl_pkg::IBL_ST_IDLE);

   assign ptr_cur = instr_ptr_sel ? ptr_flat[PTR_W +: PTR_W] : ptr_flat[0 +: PTR_W];
   // Plain 16-bit add and subtract wrap on their own, so no bound check exists.
   assign ptr_adj = instr_mode[ibl_pkg::MODE_DEC_BIT] ? ptr_cur - ibl_pkg::PTR_STEP  // see RULE5
                                                      : ptr_cur + ibl_pkg::PTR_STEP; // see RULE5
   assign acc_target = is_alias(acc_addr)
                       ? (alias_sel(acc_addr) ? ptr_flat[PTR_W +: PTR_W]            // see RULE3
                                              : ptr_flat[0 +: PTR_W])
                       : acc_addr;
   assign ptr0_r = ptr_flat[0 +: PTR_W];
   assign ptr1_r = ptr_flat[PTR_W +: PTR_W];

   ibl_ptr_file #(
      .NPTR  (2),
      .PTR_W (PTR_W)
   ) u_ptr (
      .clk      (clk),
      .rst_n    (rst_n_r),
      .ce       (ce),
      .upd_en   (mv_go),
      .upd_sel  (instr_ptr_sel),
      .upd_val  (ptr_adj),
      .ptr_flat (ptr_flat)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ibl_pkg::IBL_ST_IDLE: begin
            if (mv_go) begin
               state_nxt = ibl_pkg::IBL_ST_ACCESS;
            end
         end
         ibl_pkg::IBL_ST_ACCESS: begin
            state_nxt = mem_rd_r ? ibl_pkg::IBL_ST_CAPTURE : ibl_pkg::IBL_ST_IDLE;
         end
         ibl_pkg::IBL_ST_CAPTURE: begin
            state_nxt = ibl_pkg::IBL_ST_IDLE;
         end
         default: begin
            state_nxt = ibl_pkg::IBL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ibl_pkg::IBL_ST_IDLE;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         busy_r <= 1'b0;
      end else if (ce) begin
         busy_r <= (state_nxt != ibl_pkg::IBL_ST_IDLE);
      end
   end

   // The alias never holds data: every alias access goes out to memory at a pointer address.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mem_addr_r  <= 16'h0000;
         mem_rd_r    <= 1'b0;
         mem_wr_r    <= 1'b0;
         mem_wdata_r <= 8'h00;
      end else if (ce) begin
         mem_rd_r <= 1'b0;
         mem_wr_r <= 1'b0;
         if (mv_go) begin
            mem_addr_r  <= instr_mode[ibl_pkg::MODE_POST_BIT] ? ptr_cur : ptr_adj; // see RULE1
            mem_rd_r    <= !instr_to_mem;                                         // see RULE2
            mem_wr_r    <= instr_to_mem;                                          // see RULE2
            mem_wdata_r <= w_reg_r;                                               // see RULE4
         end else if (acc_go) begin
            mem_addr_r  <= acc_target;                                            // see RULE3
            mem_rd_r    <= !acc_we;
            mem_wr_r    <= acc_we;
            mem_wdata_r <= acc_wdata;
         end
      end
   end

   // Literal loads touch only their destination; this block drives no status flag.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         w_reg_r <= ibl_pkg::W_RST;
      end else if (ce) begin
         if (lit_go && (instr_op == ibl_pkg::IBL_OP_WORK_LIT)) begin
            w_reg_r <= instr_literal;                                             // see RULE8 RULE9
         end else if (state_r == ibl_pkg::IBL_ST_CAPTURE) begin
            w_reg_r <= mem_rdata;                                                 // see RULE2
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         bank_sel_r <= ibl_pkg::BANK_RST;
      end else if (ce && lit_go && (instr_op == ibl_pkg::IBL_OP_BANK_LIT)) begin
         bank_sel_r <= instr_literal[ibl_pkg::BANK_W-1:0];                        // see RULE6 RULE10
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         program_counter_latch_high_r <= ibl_pkg::PAGE_RST;
      end else if (ce && lit_go && (instr_op == ibl_pkg::IBL_OP_PAGE_LIT)) begin
         program_counter_latch_high_r <= instr_literal[ibl_pkg::PAGE_W-1:0];                          // see RULE7 RULE10
      end
   end

   // Checks.
   property p_mode_addr;
      @(posedge clk) disable iff (!rst_n_r)
      mv_go |=> mem_addr_r == ($past(instr_mode[1]) ? $past(ptr_cur)
                              : ($past(instr_mode[0]) ? $past(ptr_cur) - 16'h0001
                                                      : $past(ptr_cur) + 16'h0001));
   endproperty
   a_mode_addr: assert property (p_mode_addr) else $error("indirect address wrong for mode"); // see RULE1

   property p_ptr_step;
      @(posedge clk) disable iff (!rst_n_r)
      (mv_go && !instr_ptr_sel) |=> ptr0_r == ($past(instr_mode[0]) ? $past(ptr0_r) - 16'h0001
                                                                    : $past(ptr0_r) + 16'h0001);
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer not stepped with wrap"); // see RULE5

   property p_wrap_top;
      @(posedge clk) disable iff (!rst_n_r)
      (mv_go && !instr_ptr_sel && !instr_mode[0] && ptr0_r == 16'hFFFF) |=> ptr0_r == 16'h0000;
   endproperty
   a_wrap_top: assert property (p_wrap_top) else $error("pointer did not wrap at top"); // see RULE5

   property p_read_to_w;
      @(posedge clk) disable iff (!rst_n_r)
      (mv_go && !instr_to_mem) ##1 ce [*2] |=> w_reg_r == $past(mem_rdata);
   endproperty
   a_read_to_w: assert property (p_read_to_w) else $error("indirect read not loaded to W"); // see RULE2

   property p_write_from_w;
      @(posedge clk) disable iff (!rst_n_r)
      (mv_go && instr_to_mem) |=> mem_wr_r && !mem_rd_r && mem_wdata_r == $past(w_reg_r);
   endproperty
   a_write_from_w: assert property (p_write_from_w) else $error("indirect write wrong"); // see RULE4

   property p_alias_redirect;
      @(posedge clk) disable iff (!rst_n_r)
      (acc_go && is_alias(acc_addr)) |=> mem_addr_r ==
         (alias_sel($past(acc_addr)) ? ptr1_r : ptr0_r);
   endproperty
   a_alias_redirect: assert property (p_alias_redirect) else $error("alias not redirected"); // see RULE3

   property p_bank_lit;
      @(posedge clk) disable iff (!rst_n_r)
      (lit_go && instr_op == ibl_pkg::IBL_OP_BANK_LIT) |=> bank_sel_r == $past(instr_literal[5:0]);
   endproperty
   a_bank_lit: assert property (p_bank_lit) else $error("bank literal not loaded"); // see RULE6

   property p_page_lit;
      @(posedge clk) disable iff (!rst_n_r)
      (lit_go && instr_op == ibl_pkg::IBL_OP_PAGE_LIT) |=> program_counter_latch_high_r == $past(instr_literal[6:0]);
   endproperty
   a_page_lit: assert property (p_page_lit) else $error("page literal not loaded"); // see RULE7

   property p_work_lit;
      @(posedge clk) disable iff (!rst_n_r)
      (lit_go && instr_op == ibl_pkg::IBL_OP_WORK_LIT) |=> w_reg_r == $past(instr_literal);
   endproperty
   a_work_lit: assert property (p_work_lit) else $error("working literal not loaded"); // see RULE8

   property p_lit_quiet;
      @(posedge clk) disable iff (!rst_n_r)
      lit_go |=> !mem_rd_r && !mem_wr_r && $stable(ptr0_r) && $stable(ptr1_r) && !busy_r;
   endproperty
   a_lit_quiet: assert property (p_lit_quiet) else $error("literal load disturbed other state"); // see RULE9

   c_read:  cover property (@(posedge clk) disable iff (!rst_n_r) mv_go && !instr_to_mem);
   c_write: cover property (@(posedge clk) disable iff (!rst_n_r) mv_go && instr_to_mem);
   c_alias: cover property (@(posedge clk) disable iff (!rst_n_r) acc_go && is_alias(acc_addr));
   c_lit:   cover property (@(posedge clk) disable iff (!rst_n_r) lit_go);
endmodule : ibl_core

// ### common/ibl_pkg.sv
// Shared constants and types for the indirect move and literal load block.
package ibl_pkg;
   localparam int          PTR_W        = 16;
   localparam int          DATA_W       = 8;
   localparam int          BANK_W       = 6;
   localparam int          PAGE_W       = 7;
   localparam int          NPTR         = 2;
   localparam int          MODE_W       = 2;
   // Aliases of the two indirect access locations in the data space.
   localparam logic [15:0] ALIAS0_ADDR  = 16'h1F00;
   localparam logic [15:0] ALIAS1_ADDR  = 16'h1F01;
   localparam logic [1:0]  MODE_PREINC  = 2'h0;
   localparam logic [1:0]  MODE_PREDEC  = 2'h1;
   localparam logic [1:0]  MODE_POSTINC = 2'h2;
   localparam logic [1:0]  MODE_POSTDEC = 2'h3;
   localparam int          MODE_DEC_BIT = 0;
   localparam int          MODE_POST_BIT = 1;
   localparam logic [15:0] PTR_RST      = 16'h0000;
   localparam logic [15:0] PTR_STEP     = 16'h0001;
   localparam logic [7:0]  W_RST        = 8'h00;
   localparam logic [5:0]  BANK_RST     = 6'h00;
   localparam logic [6:0]  PAGE_RST     = 7'h00;
   localparam int          RD_LATENCY   = 1;

   typedef enum logic [1:0] {
      IBL_OP_INDIRECT_MOVE = 2'h0,
      IBL_OP_BANK_LIT      = 2'h1,
      IBL_OP_PAGE_LIT      = 2'h2,
      IBL_OP_WORK_LIT      = 2'h3
   } ibl_op_t;

   typedef enum logic [1:0] {
      IBL_ST_IDLE    = 2'h0,
      IBL_ST_ACCESS  = 2'h1,
      IBL_ST_CAPTURE = 2'h3
   } ibl_state_t;
endpackage : ibl_pkg

// ### verilog/ibl_ptr_file.sv
// File of the file select pointers, each a plain 16-bit register.
`timescale 1ns/100ps
module ibl_ptr_file #(
   parameter int NPTR  = ibl_pkg::NPTR,
   parameter int PTR_W = ibl_pkg::PTR_W
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    ce,
   input  wire logic                    upd_en,
   input  wire logic                    upd_sel,
   input  wire logic [PTR_W-1:0]        upd_val,
   output      logic [NPTR*PTR_W-1:0]   ptr_flat
);
   genvar g;
   generate
      for (g = 0; g < NPTR; g++) begin : g_ptr
         // Each pointer has a register of its own, so no two processes share one variable.
         logic [PTR_W-1:0] ptr_r;

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ptr_r <= PTR_W'(ibl_pkg::PTR_RST);
            end else if (ce && upd_en && (int'(upd_sel) == g)) begin
               ptr_r <= upd_val;
            end
         end
         assign ptr_flat[g*PTR_W +: PTR_W] = ptr_r;
      end
   endgenerate
endmodule : ibl_ptr_file

// ### tb/ibl_mem_model.sv
// Behavioural data memory that answers the core's registered memory port.
`timescale 1ns/100ps
module ibl_mem_model (
   input  wire logic        clk,
   input  wire logic [15:0] mem_addr_r,
   input  wire logic        mem_rd_r,
   input  wire logic        mem_wr_r,
   input  wire logic [7:0]  mem_wdata_r,
   output      logic [7:0]  mem_rdata
);
   logic [7:0] store [int];

   initial mem_rdata = 8'h00;

   always @(posedge clk) begin
      if (mem_wr_r) begin
         store[mem_addr_r] = mem_wdata_r;
      end
      // Outside a read answer the data lines churn, so a late capture cannot pass by luck.
      if (mem_rd_r) begin
         mem_rdata <= store.exists(mem_addr_r) ? store[mem_addr_r]
                      : (mem_addr_r[7:0] ^ mem_addr_r[15:8] ^ 8'h5A);
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : ibl_mem_model

// ### tb/ibl_core_tb.sv
// Self-checking bench for the indirect move and literal load core.
`timescale 1ns/100ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("BAD t=%0t %s", $time, m); end end
module ibl_core_tb;
   logic             clk, resetn, ce, instr_valid, instr_ptr_sel, instr_to_mem;
   logic             acc_valid, acc_we, mem_rd_r, mem_wr_r, busy_r;
   ibl_pkg::ibl_op_t instr_op;
   logic [1:0]       instr_mode;
   logic [7:0]       instr_literal, acc_wdata, mem_rdata, mem_wdata_r, w_reg_r, w_m;
   logic [15:0]      acc_addr, mem_addr_r, ptr0_r, ptr1_r;
   logic [5:0]       bank_sel_r, bank_m;
   logic [6:0]       program_counter_latch_high_r, page_m;
   logic [15:0]      ptr_m [2];
   logic [7:0]       mem_m [int];
   int               err_count = 0;
   int               tests_run = 0;

   ibl_core DUT (.clk(clk), .resetn(resetn), .ce(ce), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_ptr_sel(instr_ptr_sel), .instr_mode(instr_mode),
      .instr_to_mem(instr_to_mem), .instr_literal(instr_literal), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_we(acc_we), .acc_wdata(acc_wdata), .mem_rdata(mem_rdata),
      .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r),
      .mem_wdata_r(mem_wdata_r), .busy_r(busy_r), .w_reg_r(w_reg_r),
      .bank_sel_r(bank_sel_r), .program_counter_latch_high_r(program_counter_latch_high_r), .ptr0_r(ptr0_r), .ptr1_r(ptr1_r));

   ibl_mem_model u_mem (.clk(clk), .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r),
      .mem_wr_r(mem_wr_r), .mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata));

   function automatic logic [7:0] mem_at(input logic [15:0] a);
      return mem_m.exists(a) ? mem_m[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
   endfunction : mem_at

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   task automatic chk_regs();
      `CHK(w_reg_r, w_m, "working register")
      `CHK(bank_sel_r, bank_m, "bank select")
      `CHK(program_counter_latch_high_r, page_m, "page latch")
      `CHK(ptr0_r, ptr_m[0], "pointer 0")
      `CHK(ptr1_r, ptr_m[1], "pointer 1")
   endtask : chk_regs

   task automatic lit(input logic [1:0] op, input logic [7:0] k);
      instr_op      = ibl_pkg::ibl_op_t'(op);
      instr_literal = k;
      instr_valid   = 1'b1;
      @(negedge clk);
      if (op == 2'h1) bank_m = k[5:0];
      else if (op == 2'h2) page_m = k[6:0];
      else w_m = k;
      chk_regs();
   endtask : lit

   task automatic move(input logic sel, input logic [1:0] mode, input logic dir);
      logic [15:0] np;
      logic [15:0] a;
      int          n;
      np = mode[ibl_pkg::MODE_DEC_BIT] ? ptr_m[sel] - 16'h0001 : ptr_m[sel] + 16'h0001;
      a = mode[ibl_pkg::MODE_POST_BIT] ? ptr_m[sel] : np;
      ptr_m[sel] = np;
      instr_op      = ibl_pkg::IBL_OP_INDIRECT_MOVE;
      instr_ptr_sel = sel;
      instr_mode    = mode;
      instr_to_mem  = dir;
      instr_valid   = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      `CHK(busy_r, 1'b1, "busy during move")
      `CHK(mem_addr_r, a, "move address")
      `CHK(mem_rd_r, ~dir, "move read strobe")
      `CHK(mem_wr_r, dir, "move write strobe")
      if (dir) begin
         `CHK(mem_wdata_r, w_m, "move write data")
         mem_m[a] = w_m;
      end else begin
         w_m = mem_at(a);
      end
      n = 0;
      while (busy_r !== 1'b0 && n < 6) begin
         @(negedge clk);
         n++;
      end
      `CHK(n, dir ? 1 : 2, "move cycle count")
      chk_regs();
   endtask : move

   task automatic acc(input logic [15:0] addr, input logic we, input logic [7:0] d);
      logic [15:0] a;
      a = (addr == ibl_pkg::ALIAS0_ADDR) ? ptr_m[0]
          : (addr == ibl_pkg::ALIAS1_ADDR) ? ptr_m[1] : addr;
      instr_valid = 1'b0;
      acc_valid   = 1'b1;
      acc_addr    = addr;
      acc_we      = we;
      acc_wdata   = d;
      @(negedge clk);
      acc_valid = 1'b0;
      `CHK(mem_addr_r, a, "access address")
      `CHK(mem_wr_r, we, "access write strobe")
      `CHK(mem_rd_r, ~we, "access read strobe")
      if (we) begin
         `CHK(mem_wdata_r, d, "access write data")
         mem_m[a] = d;
         // An edge passes so that the next request never raises the strobe just lowered.
         @(negedge clk);
      end else begin
         @(negedge clk);
         `CHK(mem_rdata, mem_at(a), "access read data")
      end
   endtask : acc

   // Clock enable low must hold every register and strobe, even with an instruction waiting.
   task automatic frozen(input logic [7:0] k);
      ce            = 1'b0;
      instr_op      = ibl_pkg::IBL_OP_WORK_LIT;
      instr_literal = k;
      instr_valid   = 1'b1;
      repeat (3) @(negedge clk);
      chk_regs();
      `CHK(mem_rd_r | mem_wr_r, 1'b0, "strobe while frozen")
      ce = 1'b1;
      @(negedge clk);
      w_m = k;
      chk_regs();
   endtask : frozen

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Roughly 515 operations of at most four cycles each fit well inside this span.
   initial begin
      #100000;
      err_count++;
      complete_run();
   end

   initial begin
      {resetn, ce, instr_valid, instr_ptr_sel, instr_to_mem, acc_valid, acc_we} = 7'h00;
      instr_op = ibl_pkg::IBL_OP_INDIRECT_MOVE;
      {instr_mode, instr_literal, acc_wdata, acc_addr} = 34'h0;
      {w_m, bank_m, page_m} = 21'h0;
      ptr_m[0] = 16'h0000;
      ptr_m[1] = 16'h0000;
      void'($urandom(91846));
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      ce     = 1'b1;
      repeat (3) @(negedge clk);
      chk_regs();
      move(1'b0, ibl_pkg::MODE_PREDEC, 1'b0);
      lit(2'h3, 8'hA7);
      move(1'b0, ibl_pkg::MODE_PREINC, 1'b1);
      move(1'b1, ibl_pkg::MODE_POSTDEC, 1'b0);
      move(1'b1, ibl_pkg::MODE_POSTINC, 1'b1);
      lit(2'h1, 8'hFF);
      lit(2'h2, 8'hFF);
      lit(2'h3, 8'hFF);
      lit(2'h1, 8'h40);
      lit(2'h2, 8'h80);
      lit(2'h3, 8'h00);
      acc(ibl_pkg::ALIAS0_ADDR, 1'b1, 8'hC3);
      acc(ibl_pkg::ALIAS0_ADDR, 1'b0, 8'h00);
      acc(ibl_pkg::ALIAS1_ADDR, 1'b0, 8'h00);
      acc(16'h0123, 1'b0, 8'h00);
      frozen(8'h3C);
      repeat (500) begin
         case ($urandom_range(0, 4))
            0: move(1'($urandom), 2'($urandom), 1'($urandom));
            1: acc({15'h0F80, 1'($urandom)}, 1'($urandom), 8'($urandom));
            2: acc(16'($urandom_range(0, 15)), 1'($urandom), 8'($urandom));
            default: lit(2'($urandom_range(1, 3)), 8'($urandom));
         endcase
      end
      instr_valid = 1'b0;
      complete_run();
   end
endmodule : ibl_core_tb
